// ===== v34_rate_regs.vh
/*
  Register offsets, field positions, reset values, codes and timing counts
  for the V.34 data rate negotiation block.
  Assumes a byte-wide register port with a 10-bit address.
*/
`ifndef V34_RATE_REGS_VH
`define V34_RATE_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_ABORT_REASON        10'h014
`define OFS_CONTROL             10'h015
`define OFS_STATUS              10'h016
`define OFS_CONFIG_CODE         10'h017
`define OFS_SELECTED_RATE       10'h018
`define OFS_PREFERRED_RATE      10'h30a
`define OFS_MAX_ALLOWED_RATE    10'h37a
`define OFS_MASK_LOW            10'h382
`define OFS_MASK_HIGH           10'h383

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_AUTO_RATE_ENABLE    0
`define CTL_RATE_CONTROL_BIT    1
`define CTL_RECIPIENT           2
`define CTL_INITIATOR           3
`define STS_STAGE_A             0
`define STS_STAGE_B             1
`define STS_STAGE_C             2
`define STS_MPH_RX              3
`define STS_RATE_VALID          4
`define STS_ABORTED             5

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define RST_MAX_ALLOWED_RATE    8'h0c
`define RST_PREFERRED_RATE      8'h0c
`define RST_CONFIG_CODE         8'haa
`define RST_MASK_LOW            8'hff
`define RST_MASK_HIGH           8'hff
`define RST_CONTROL             8'h00
`define CONFIG_V8_MODE          8'haa
`define RATE_CODE_TOP           4'he
`define ABORT_NONE              8'h00
`define ABORT_STAGE_A           8'h01
`define ABORT_STAGE_B           8'h02
`define ABORT_STAGE_C           8'h03
`define ABORT_MPH               8'h04
`define ABORT_NO_COMMON         8'h05

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ                 100
`define STAGE_TIMEOUT_US        10000
`define STAGE_TIMEOUT_CYCLES    (`STAGE_TIMEOUT_US * `CLK_MHZ)

`endif

// ===== rate_pick.v
/*
  Picks the highest rate enabled in a 14-bit mask whose code does not exceed
  a limit code. Code c stands for c times 2400 bps; bit n of the mask is code
  n+1. A result of zero means no rate qualifies.
  Assumes a purely combinational use.
*/
`timescale 1ns/1ps
`default_nettype none

module rate_pick (
  // Candidates
  input  wire [13:0] i_mask,
  input  wire [3:0]  i_limit,
  // Result
  output reg  [3:0]  o_code
);

  integer n;

  always @* begin
    o_code = 4'h0;
    for (n = 0; n < 14; n = n + 1) begin
      if (i_mask[n] && (n + 1 <= i_limit)) begin
        o_code = n[3:0] + 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== stage_timer.v
/*
  Watchdog for one handshake stage: counts while armed and flags expiry.
  Assumes restart pulses when a new stage begins.
*/
`timescale 1ns/1ps
`default_nettype none

module stage_timer #(
  parameter LIMIT = 1000000
) (
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_rst_n,
  // Control
  input  wire i_restart,
  input  wire i_run,
  // Status
  output wire o_expired
);

  reg [23:0] count;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 24'h00_0000;
    end else if (i_restart || !i_run) begin
      count <= 24'h00_0000;
    end else if (!o_expired) begin
      count <= count + 24'h00_0001;
    end
  end

  assign o_expired = i_run && (count == LIMIT[23:0] - 24'h00_0001);

endmodule

`default_nettype wire

// ===== v34_rate_negotiation.v
/*
  V.34 half-duplex primary channel data rate negotiation: register file,
  handshake sequencer with stage watchdog, MPh build and compare, abort
  reporting.
  Assumes a byte register port with read data one cycle after the strobe,
  and line-side event pulses from the modem datapath.
*/
// Our own choice: the plain strobed port.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "v34_rate_regs.vh"

module v34_rate_negotiation #(
  parameter STAGE_TIMEOUT = `STAGE_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // Register port
  input  wire [9:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // Host control lines
  input  wire        i_dtr,
  input  wire        i_rts,
  // Line-side events
  input  wire        i_start,
  input  wire        i_v8_done,
  input  wire        i_stage_a,
  input  wire        i_stage_b,
  input  wire        i_stage_c,
  input  wire [3:0]  i_ara_code,
  input  wire        i_mph_rx_valid,
  input  wire [13:0] i_mph_rx_mask,
  input  wire [3:0]  i_mph_rx_max,
  // Line-side results
  output reg         o_train_tx,
  output reg         o_mph_tx_valid,
  output reg  [13:0] o_mph_tx_mask,
  output reg  [3:0]  o_mph_tx_max,
  output reg  [3:0]  o_rate_code,
  output reg         o_rate_valid,
  output reg         o_cleardown
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE    = 3'd0;
  localparam [2:0] ST_WAIT_A  = 3'd1;
  localparam [2:0] ST_WAIT_B  = 3'd2;
  localparam [2:0] ST_WAIT_C  = 3'd3;
  localparam [2:0] ST_SEND    = 3'd4;
  localparam [2:0] ST_WAIT_MP = 3'd5;
  localparam [2:0] ST_PRIMARY = 3'd6;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  abort_reason_code;
  reg  [7:0]  control;
  reg  [5:0]  status;
  reg  [7:0]  config_code;
  reg  [7:0]  preferred_connect_rate;
  reg  [7:0]  max_allowed_rate;
  reg  [7:0]  rate_enable_mask_low;
  reg  [7:0]  rate_enable_mask_high;
  reg  [2:0]  state;
  reg         resync;
  reg         rts_q;
  reg         dtr_q;

  wire        auto_rate_enable = control[`CTL_AUTO_RATE_ENABLE];
  wire        recipient        = control[`CTL_RECIPIENT];
  wire        initiator        = control[`CTL_INITIATOR];
  wire [15:0] mask16           = {rate_enable_mask_high, rate_enable_mask_low};
  wire [13:0] mask             = mask16[13:0];
  wire        wr_status        = i_wr && (i_addr == `OFS_STATUS);
  wire        rts_drop         = rts_q && !i_rts;
  wire        dtr_rise         = i_dtr && !dtr_q;

  // --------------------------------------------------------------------------
  // Local maximum preferred rate
  // --------------------------------------------------------------------------
  // The smaller of two codes; neither input is limited to the top code.
  function [3:0] min4;
    input [3:0] a;
    input [3:0] b;
    begin
      min4 = (a < b) ? a : b;
    end
  endfunction

  reg  [3:0] pref_limit;

  always @* begin
    if (resync) begin
      // Adaptation results are ignored between pages.
      if (initiator) begin
        pref_limit = min4(config_code[3:0], max_allowed_rate[3:0]);
      end else begin
        pref_limit = `RATE_CODE_TOP;
      end
    end else if (recipient && auto_rate_enable) begin
      pref_limit = min4(i_ara_code, max_allowed_rate[3:0]);
    end else begin
      pref_limit = min4(min4(preferred_connect_rate[3:0], config_code[3:0]),
                        max_allowed_rate[3:0]);
    end
  end

  wire [3:0] local_max;

  rate_pick u_local_pick (
    .i_mask  (mask),
    .i_limit (pref_limit),
    .o_code  (local_max)
  );

  // Rates at or below the local maximum, further cut by the mask.
  reg  [13:0] local_mask;
  integer     k;

  always @* begin
    local_mask = 14'h0000;
    for (k = 0; k < 14; k = k + 1) begin
      local_mask[k] = mask[k] && (k + 1 <= local_max);
    end
  end

  // --------------------------------------------------------------------------
  // Common rate against the received MPh
  // --------------------------------------------------------------------------
  wire [3:0] common_rate;

  rate_pick u_common_pick (
    .i_mask  (local_mask & i_mph_rx_mask),
    .i_limit (min4(local_max, i_mph_rx_max)),
    .o_code  (common_rate)
  );

  // --------------------------------------------------------------------------
  // Stage watchdog
  // --------------------------------------------------------------------------
  wire timer_run = (state == ST_WAIT_A) || (state == ST_WAIT_B) ||
                   (state == ST_WAIT_C) || (state == ST_WAIT_MP);
  wire stage_hit = ((state == ST_WAIT_A) && i_stage_a) ||
                   ((state == ST_WAIT_B) && i_stage_b) ||
                   ((state == ST_WAIT_C) && i_stage_c);
  wire timed_out;

  stage_timer #(
    .LIMIT (STAGE_TIMEOUT)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_restart (stage_hit),
    .i_run     (timer_run),
    .o_expired (timed_out)
  );

  // --------------------------------------------------------------------------
  // Handshake sequencer
  // --------------------------------------------------------------------------
  reg [7:0] abort_code_now;

  always @* begin
    case (state)
      ST_WAIT_A:  abort_code_now = `ABORT_STAGE_A;
      ST_WAIT_B:  abort_code_now = `ABORT_STAGE_B;
      ST_WAIT_C:  abort_code_now = `ABORT_STAGE_C;
      default:    abort_code_now = `ABORT_MPH;
    endcase
  end

  wire start_now = ((state == ST_IDLE) && i_start) ||
                   ((state == ST_PRIMARY) && rts_drop);

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state             <= ST_IDLE;
      resync            <= 1'b0;
      abort_reason_code <= `ABORT_NONE;
      o_train_tx        <= 1'b0;
      o_mph_tx_valid    <= 1'b0;
      o_mph_tx_mask     <= 14'h0000;
      o_mph_tx_max      <= 4'h0;
      o_rate_code       <= 4'h0;
      o_rate_valid      <= 1'b0;
      o_cleardown       <= 1'b0;
    end else begin
      o_mph_tx_valid <= 1'b0;
      o_cleardown    <= 1'b0;
      if (start_now) begin
        // A new handshake leaves the last abort code in place.
        state        <= ST_WAIT_A;
        resync       <= (state == ST_PRIMARY);
        o_train_tx   <= 1'b1;
        o_rate_valid <= 1'b0;
      end else if (timed_out) begin
        state             <= ST_IDLE;
        o_train_tx        <= 1'b0;
        abort_reason_code <= abort_code_now;
      end else begin
        case (state)
          ST_WAIT_A: begin
            if (i_stage_a) begin
              state <= ST_WAIT_B;
            end
          end
          ST_WAIT_B: begin
            if (i_stage_b) begin
              state <= ST_WAIT_C;
            end
          end
          ST_WAIT_C: begin
            if (i_stage_c) begin
              state <= ST_SEND;
            end
          end
          ST_SEND: begin
            o_mph_tx_valid <= 1'b1;
            o_mph_tx_mask  <= local_mask;
            o_mph_tx_max   <= local_max;
            state          <= ST_WAIT_MP;
          end
          ST_WAIT_MP: begin
            if (i_mph_rx_valid) begin
              o_train_tx <= 1'b0;
              if (common_rate == 4'h0) begin
                abort_reason_code <= `ABORT_NO_COMMON;
                o_cleardown       <= 1'b1;
                state             <= ST_IDLE;
              end else begin
                o_rate_code  <= common_rate;
                o_rate_valid <= 1'b1;
                state        <= ST_PRIMARY;
              end
            end
          end
          ST_PRIMARY: begin
            state <= ST_PRIMARY;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status flags: hardware set wins over a write-one clear
  // --------------------------------------------------------------------------
  wire [3:0] status_set = {i_mph_rx_valid, i_stage_c, i_stage_b, i_stage_a};

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= 6'h00;
    end else begin
      status[3:0] <= (status[3:0] & ~(wr_status ? i_wdata[3:0] : 4'h0)) | status_set;
      status[`STS_RATE_VALID] <= o_rate_valid;
      if (timed_out || (state == ST_WAIT_MP && i_mph_rx_valid && common_rate == 4'h0)) begin
        status[`STS_ABORTED] <= 1'b1;
      end else if (wr_status && i_wdata[`STS_ABORTED]) begin
        status[`STS_ABORTED] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Host-visible registers
  // --------------------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control                <= `RST_CONTROL;
      config_code            <= `RST_CONFIG_CODE;
      preferred_connect_rate <= `RST_PREFERRED_RATE;
      max_allowed_rate       <= `RST_MAX_ALLOWED_RATE;
      rate_enable_mask_low   <= `RST_MASK_LOW;
      rate_enable_mask_high  <= `RST_MASK_HIGH;
      rts_q                  <= 1'b0;
      dtr_q                  <= 1'b0;
    end else begin
      rts_q <= i_rts;
      dtr_q <= i_dtr;
      if (i_wr) begin
        case (i_addr)
          `OFS_CONTROL:          control                <= {4'h0, i_wdata[3:0]};
          `OFS_CONFIG_CODE:      config_code            <= i_wdata;
          `OFS_PREFERRED_RATE:   preferred_connect_rate <= i_wdata;
          `OFS_MAX_ALLOWED_RATE: max_allowed_rate       <= i_wdata;
          `OFS_MASK_LOW:         rate_enable_mask_low   <= i_wdata;
          `OFS_MASK_HIGH:        rate_enable_mask_high  <= i_wdata;
          default:               control                <= control;
        endcase
      end
      // Hardware updates follow host writes in the same cycle, so they win.
      if (dtr_rise && (config_code == `CONFIG_V8_MODE)) begin
        max_allowed_rate <= {4'h0, preferred_connect_rate[3:0]};
      end
      if (i_v8_done) begin
        config_code <= preferred_connect_rate;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port: data stand in the cycle after the strobe only
  // --------------------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OFS_ABORT_REASON:     o_rdata <= abort_reason_code;
        `OFS_CONTROL:          o_rdata <= control;
        `OFS_STATUS:           o_rdata <= {2'b00, status};
        `OFS_CONFIG_CODE:      o_rdata <= config_code;
        `OFS_SELECTED_RATE:    o_rdata <= {4'h0, o_rate_code};
        `OFS_PREFERRED_RATE:   o_rdata <= preferred_connect_rate;
        `OFS_MAX_ALLOWED_RATE: o_rdata <= max_allowed_rate;
        `OFS_MASK_LOW:         o_rdata <= rate_enable_mask_low;
        `OFS_MASK_HIGH:        o_rdata <= rate_enable_mask_high;
        default:               o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ===== v34_rate_negotiation_chk.sv
/*
  Checker for the rate negotiation block: stage timeouts and the rate pick.
  Assumes it is bound to the block's top module with one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module v34_rate_negotiation_chk #(
  parameter STAGE_TIMEOUT = 1000000
) (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  // Line-side events
  input wire logic        i_stage_a,
  input wire logic        i_stage_b,
  input wire logic        i_stage_c,
  input wire logic        i_mph_rx_valid,
  input wire logic [13:0] i_mph_rx_mask,
  input wire logic [3:0]  i_mph_rx_max,
  // Line-side results
  input wire logic        o_train_tx,
  input wire logic        o_mph_tx_valid,
  input wire logic [13:0] o_mph_tx_mask,
  input wire logic [3:0]  o_mph_tx_max,
  input wire logic [3:0]  o_rate_code,
  input wire logic        o_rate_valid,
  input wire logic        o_cleardown
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // ------------------------
  // Helper state
  // ------------------------
  // The idle count restarts on every stage event, so it shows the wait of one stage only.
  logic       mph_sent;
  logic       train_q;
  logic [3:0] exp_best;
  logic [3:0] lim;
  int         idle_cnt;

  function automatic logic [3:0] best(input logic [13:0] m, input logic [3:0] l);
    best = 4'h0;
    for (int k = 1; k < 15; k++)
      if (k <= l && m[k-1]) best = 4'(k);
  endfunction

  assign lim = (o_mph_tx_max < i_mph_rx_max) ? o_mph_tx_max : i_mph_rx_max;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mph_sent <= 1'b0;
      train_q  <= 1'b0;
      exp_best <= 4'h0;
      idle_cnt <= 0;
    end else begin
      train_q  <= o_train_tx;
      mph_sent <= o_train_tx && (mph_sent || o_mph_tx_valid);
      exp_best <= best(o_mph_tx_mask & i_mph_rx_mask, lim);
      if (!o_train_tx || !train_q || i_stage_a || i_stage_b || i_stage_c || o_mph_tx_valid)
        idle_cnt <= 0;
      else
        idle_cnt <= idle_cnt + 1;
    end
  end

  // ------------------------
  // Properties
  // ------------------------
  property p_timeout_late;
    idle_cnt <= STAGE_TIMEOUT + 3;
  endproperty
  a_timeout_late: assert property (p_timeout_late)
    else $error("training held past the stage timeout");

  property p_timeout_early;
    $fell(o_train_tx) && !$past(i_mph_rx_valid) |-> $past(idle_cnt) + 3 >= STAGE_TIMEOUT;
  endproperty
  a_timeout_early: assert property (p_timeout_early)
    else $error("training stopped before the stage timeout");

  property p_pick;
    i_mph_rx_valid && mph_sent |=> exp_best == 4'h0 || (o_rate_valid && o_rate_code == exp_best);
  endproperty
  a_pick: assert property (p_pick)
    else $error("selected rate is not the highest common rate");

  property p_no_common;
    i_mph_rx_valid && mph_sent |=> exp_best != 4'h0 || (o_cleardown && !o_rate_valid);
  endproperty
  a_no_common: assert property (p_no_common)
    else $error("no cleardown although no rate is shared");

  property p_train_drop;
    i_mph_rx_valid && mph_sent |=> !o_train_tx;
  endproperty
  a_train_drop: assert property (p_train_drop)
    else $error("training still sent after the MPh compare");

  property p_cleardown_one;
    o_cleardown |=> !o_cleardown;
  endproperty
  a_cleardown_one: assert property (p_cleardown_one)
    else $error("cleardown longer than one cycle");

  property p_mph_after_c;
    $rose(o_mph_tx_valid) |-> $past(i_stage_c, 2);
  endproperty
  a_mph_after_c: assert property (p_mph_after_c)
    else $error("MPh sent without a preceding stage c");

  property p_rate_masks;
    $rose(o_rate_valid) |-> o_rate_code != 4'h0 && o_rate_code <= o_mph_tx_max
                            && o_mph_tx_mask[o_rate_code - 4'h1];
  endproperty
  a_rate_masks: assert property (p_rate_masks)
    else $error("selected rate is masked off or above the local maximum");

  c_rate: cover property ($rose(o_rate_valid));
  c_clear: cover property (o_cleardown);
  c_abort: cover property ($fell(o_train_tx) && !$past(i_mph_rx_valid));
endmodule

bind v34_rate_negotiation v34_rate_negotiation_chk #(.STAGE_TIMEOUT(STAGE_TIMEOUT)) chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_stage_a(i_stage_a), .i_stage_b(i_stage_b),
  .i_stage_c(i_stage_c), .i_mph_rx_valid(i_mph_rx_valid), .i_mph_rx_mask(i_mph_rx_mask),
  .i_mph_rx_max(i_mph_rx_max), .o_train_tx(o_train_tx), .o_mph_tx_valid(o_mph_tx_valid),
  .o_mph_tx_mask(o_mph_tx_mask), .o_mph_tx_max(o_mph_tx_max), .o_rate_code(o_rate_code),
  .o_rate_valid(o_rate_valid), .o_cleardown(o_cleardown));

`default_nettype wire

// ===== remote_modem.sv
/*
  Behavioural far-end modem: answers training with stages a, b, c and an MPh.
  Assumes the bench sets delay, stall point, mask and maximum between handshakes.
*/
`timescale 1ns/1ps
`default_nettype none

module remote_modem (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Behaviour set by the bench
  input  wire logic [3:0]  i_delay,
  input  wire logic [2:0]  i_stall,
  input  wire logic [13:0] i_mask,
  input  wire logic [3:0]  i_max,
  // Line from the local modem
  input  wire logic        i_train,
  input  wire logic        i_mph_tx_valid,
  // Line toward the local modem
  output logic             o_stage_a,
  output logic             o_stage_b,
  output logic             o_stage_c,
  output logic             o_mph_valid,
  output logic [13:0]      o_mph_mask,
  output logic [3:0]       o_mph_max
);
  logic [2:0] step;
  logic [3:0] cnt;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step <= 3'h0;
      cnt <= 4'h0;
      {o_stage_a, o_stage_b, o_stage_c, o_mph_valid} <= 4'h0;
      o_mph_mask <= 14'h0000;
      o_mph_max <= 4'h0;
    end else begin
      {o_stage_a, o_stage_b, o_stage_c, o_mph_valid} <= 4'h0;
      // Outside the step pulses (stages a, b, c and MPh) the data lines toggle, so stale values never look valid.
      o_mph_mask <= ~o_mph_mask;
      o_mph_max <= ~o_mph_max;
      if (!i_train) begin
        step <= 3'h0;
        cnt <= i_delay;
      end else if (step == 3'h3) begin
        if (i_mph_tx_valid) step <= 3'h4;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (step < 3'h5 && step != i_stall) begin
        cnt <= i_delay;
        step <= step + 3'h1;
        o_stage_a <= step == 3'h0;
        o_stage_b <= step == 3'h1;
        o_stage_c <= step == 3'h2;
        o_mph_valid <= step == 3'h4;
        o_mph_mask <= i_mask;
        o_mph_max <= i_max;
      end
    end
  end
endmodule

`default_nettype wire

// ===== v34_rate_negotiation_test.sv
/*
  Self-checking bench for the rate negotiation block.
  Assumes the remote modem model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module v34_rate_negotiation_test;
  // ------------------------
  // Wiring
  // ------------------------
  // A short stage timeout keeps the abort cases quick.
  localparam int TMO = 20;
  typedef struct packed {
    logic [15:0] m;
    logic [7:0]  p, x, c;
    logic [3:0]  a;
    logic [13:0] rm;
    logic [3:0]  rx, e;
  } row_t;
  // Mask, preferred, max allowed, control, adaptation, remote mask, remote max, rate.
  row_t rows [11] = '{
    '{16'hffff, 8'h0c, 8'h0c, 8'h00, 4'h0, 14'h3fff, 4'he, 4'hc},
    '{16'hffff, 8'h0e, 8'h0c, 8'h00, 4'h0, 14'h3fff, 4'he, 4'hc},
    '{16'hf7ff, 8'h0c, 8'h0e, 8'h00, 4'h0, 14'h3fff, 4'he, 4'hb},
    '{16'hffff, 8'h0c, 8'h0c, 8'h05, 4'h7, 14'h3fff, 4'he, 4'h7},
    '{16'hffff, 8'h09, 8'h0c, 8'h04, 4'h7, 14'h3fff, 4'he, 4'h9},
    '{16'hffff, 8'h08, 8'h0c, 8'h01, 4'h3, 14'h3fff, 4'he, 4'h8},
    '{16'hffff, 8'h0c, 8'h0c, 8'h00, 4'h0, 14'h00ff, 4'he, 4'h8},
    '{16'hffff, 8'h0c, 8'h0c, 8'h04, 4'h0, 14'h3fff, 4'h5, 4'h5},
    '{16'hc0f0, 8'h0c, 8'h0c, 8'h00, 4'h0, 14'h000f, 4'he, 4'h0},
    '{16'hffff, 8'h01, 8'h0c, 8'h00, 4'h0, 14'h3fff, 4'he, 4'h1},
    '{16'hc7ff, 8'h0c, 8'h0c, 8'h00, 4'h0, 14'h3fff, 4'he, 4'hb}};
  logic [9:0]  rst_addr [8] = '{10'h014, 10'h37a, 10'h30a, 10'h017, 10'h382, 10'h383, 10'h015, 10'h100};
  logic [7:0]  rst_val [8] = '{8'h00, 8'h0c, 8'h0c, 8'haa, 8'hff, 8'hff, 8'h00, 8'h00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0, rd = 1'b0, dtr = 1'b0, rts = 1'b1, start = 1'b0, v8 = 1'b0;
  logic [3:0]  auto_rate_adapt = 4'h0, rmax = 4'he, rdly = 4'h0;
  logic [2:0]  stall = 3'h7;
  logic [13:0] rmask = 14'h3fff;
  wire         sa, sb, sc, rxv, train, txv, rv, clr;
  wire  [13:0] rxm, txm;
  wire  [3:0]  rxx, txx, rate;
  wire  [7:0]  rdata;
  int          failures = 0;
  int          comparisons = 0;

  v34_rate_negotiation #(.STAGE_TIMEOUT(TMO)) v34_rate_negotiation_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_dtr(dtr), .i_rts(rts), .i_start(start), .i_v8_done(v8),
    .i_stage_a(sa), .i_stage_b(sb), .i_stage_c(sc), .i_ara_code(auto_rate_adapt), .i_mph_rx_valid(rxv),
    .i_mph_rx_mask(rxm), .i_mph_rx_max(rxx), .o_train_tx(train), .o_mph_tx_valid(txv),
    .o_mph_tx_mask(txm), .o_mph_tx_max(txx), .o_rate_code(rate), .o_rate_valid(rv),
    .o_cleardown(clr));
  remote_modem remote_modem_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_delay(rdly), .i_stall(stall), .i_mask(rmask),
    .i_max(rmax), .i_train(train), .i_mph_tx_valid(txv), .o_stage_a(sa), .o_stage_b(sb),
    .o_stage_c(sc), .o_mph_valid(rxv), .o_mph_mask(rxm), .o_mph_max(rxx));

  always #5 clk = ~clk;

  // ------------------------
  // Tasks
  // ------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask

  task automatic pulse_v8;
    @(posedge clk);
    v8 <= 1'b1;
    @(posedge clk);
    v8 <= 1'b0;
  endtask

  // Mask rows keep the two reserved top bits set, as the host must.
  task automatic setup(input row_t r);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(10'h382, r.m[7:0]);
    wr_reg(10'h383, r.m[15:8]);
    wr_reg(10'h30a, r.p);
    wr_reg(10'h37a, r.x);
    wr_reg(10'h015, r.c);
    auto_rate_adapt <= r.a;
    rmask <= r.rm;
    rmax <= r.rx;
    pulse_v8;
  endtask

  // Starts a handshake, or a resync if by_rts, and waits for training to end.
  task automatic hs(input bit by_rts);
    int n;
    @(posedge clk);
    if (by_rts) rts <= 1'b0;
    else start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rts <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((train === 1'b1 || n < 3) && n < 400);
    check(train, 1'b0);
  endtask

  // ------------------------
  // Tests
  // ------------------------
  initial begin
    foreach (rows[k]) begin
      setup(rows[k]);
      rdly <= (k % 2) ? 4'hc : 4'h0;
      hs(1'b0);
      check({rv, clr, rate}, {rows[k].e != 4'h0, rows[k].e == 4'h0, rows[k].e});
      if (rows[k].e == 4'h0) rd_reg(10'h014, 8'h05);
      $display("row %0d done", k);
    end
    // The last row leaves the link in the primary channel.
    wr_reg(10'h017, 8'h05);
    hs(1'b1);
    check({txx, rate}, 8'hbb);
    wr_reg(10'h015, 8'h0d);
    hs(1'b1);
    check({txx, rate}, 8'h55);
    $display("resync test done");
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_addr[k]) rd_reg(rst_addr[k], rst_val[k]);
    wr_reg(10'h014, 8'h55);
    wr_reg(10'h382, 8'h5a);
    wr_reg(10'h383, 8'hc3);
    rd_reg(10'h014, 8'h00);
    rd_reg(10'h382, 8'h5a);
    rd_reg(10'h383, 8'hc3);
    wr_reg(10'h30a, 8'h0b);
    dtr <= 1'b1;
    rd_reg(10'h37a, 8'h0b);
    pulse_v8;
    dtr <= 1'b0;
    rd_reg(10'h017, 8'h0b);
    $display("register test done");
    setup(rows[0]);
    for (int k = 0; k < 4; k++) begin
      stall <= (k == 3) ? 3'h4 : 3'(k);
      hs(1'b0);
      rd_reg(10'h014, 8'(k + 1));
      if (k == 2) rd_reg(10'h016, 8'h23);
    end
    stall <= 3'h7;
    hs(1'b0);
    check({rv, rate}, 5'h1c);
    rd_reg(10'h014, 8'h04);
    $display("timeout test done");
    stop_test;
  end

  // The whole run takes under 1000 cycles; the watchdog allows 20000 cycles, over twenty times that.
  initial begin
    #200000;
    failures++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    stop_test;
  end
endmodule

`default_nettype wire
